// file: daq_adc_model.sv
/* Converter model behind the add-on control logic.
   Assumes one start pulse per conversion; answers lat cycles later. */
`timescale 1ns/1ps
module daq_adc_model
  import daq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic [11:0] value,
  input wire logic [7:0] lat,
  output daq_adc_s adc
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= 8'h00;
      adc <= '{done: 1'b0, data: 12'hfff};
    end else begin
      adc.done <= 1'b0;
      // Data is only held with done
      if (adc.done) adc.data <= ~adc.data;
      if (start) cnt_r <= lat;
      else if (cnt_r == 8'h01) begin
        adc <= '{done: 1'b1, data: value};
        cnt_r <= 8'h00;
      end else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : daq_adc_model

// file: daq_addon_control_logic_tb_top.sv
/* Self-checking bench for the add-on control logic.
   Assumes the converter model and bound checker are compiled first. */
`timescale 1ns/1ps
module daq_addon_control_logic_tb_top;
  import daq_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  daq_io_req_s io_req = '0;
  logic [31:0] io_rdata_r, rv, r;
  logic io_rvalid_r, adc_start_r, tmr1_gate_r, host_irq_n_r, tmr_clk_r;
  logic [15:0] din = '0;
  logic [15:0] dout_r;
  logic single_ended = 1'b1;
  logic ext_trig = 1'b1;
  daq_tmr_out_s tmr_out = '0;
  daq_adc_s adc_in;
  logic [4:0] chan_sel_r;
  logic [1:0] gain_r;
  logic [11:0] conv_val = 12'h000;
  int error_cnt = 0;
  int samples_checked = 0;
  int starts = 0;
  int tclk_n = 0;
  logic tclk_p;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (adc_start_r === 1'b1) starts++;
  daq_addon_ctl dut_u (.clk_sys(clk_sys), .srst(srst), .io_req(io_req), .io_rdata_r(io_rdata_r),
    .io_rvalid_r(io_rvalid_r), .parallel_input_lines(din), .dout_r(dout_r), .single_ended(single_ended),
    .ext_trig(ext_trig), .tmr_out(tmr_out), .tmr_clk_r(tmr_clk_r), .tmr1_gate_r(tmr1_gate_r), .adc_in(adc_in),
    .adc_start_r(adc_start_r), .chan_sel_r(chan_sel_r), .gain_r(gain_r), .host_irq_n_r(host_irq_n_r));
  daq_adc_model adc_u (.clk_sys(clk_sys), .srst(srst), .start(adc_start_r), .value(conv_val), .lat(8'h0c),
    .adc(adc_in));
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic br, input logic w, input logic [6:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    io_req = '{sel_bridge: br, sel_addon: !br, rd: !w, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    io_req = '0;
    chk("rvalid", 32'(!w), 32'(io_rvalid_r));
    rv = io_rdata_r;
    @(negedge clk_sys);
  endtask : acc
  task automatic ext_pulse;
    @(negedge clk_sys) ext_trig = 1'b0;
    repeat (3) @(negedge clk_sys);
    ext_trig = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask : ext_pulse
  function automatic logic [31:0] status_exp(input logic [31:0] v);
    return {24'h0, v[1:0], v[7], v[8], v[6], 1'b0, v[5], 1'b0};
  endfunction : status_exp
  initial begin
    #300000;
    error_cnt++;
    results();
  end
  initial begin
    void'($urandom(32'h4f3f));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) srst = 1'b0;
    acc(1, 0, OFS_HOST_IRQ_GATE, 0);
    chk("gate", 32'h0, rv);
    chk("chan gain", 32'h0, 32'({chan_sel_r, gain_r}));
    acc(0, 0, OFS_TRIG_IRQ_CTL, 0);
    chk("wo read", 32'h0, rv);
    acc(0, 0, 7'h3c, 0);
    chk("unmapped", 32'h0, rv);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      din = r[31:16];
      single_ended = r[5];
      tmr_out = r[8:6];
      acc(0, 1, OFS_DIGITAL, r);
      chk("dout", 32'(r[15:0]), 32'(dout_r));
      acc(0, 0, OFS_DIGITAL, 0);
      chk("din", 32'(r[31:16]), rv);
      acc(0, 1, OFS_CHAN_STATUS, r);
      chk("chan", 32'(r[4:0] & {r[5], 4'hf}), 32'(chan_sel_r));
      acc(0, 1, OFS_GAIN, r);
      chk("gain", 32'(r[1:0]), 32'(gain_r));
      acc(0, 0, OFS_CHAN_STATUS, 0);
      chk("status", status_exp(r), rv & 32'hfe);
    end
    $display("test registers done");
    tmr_out = '0;
    repeat (20) @(negedge clk_sys);
    acc(0, 1, OFS_TRIG_IRQ_CTL, 32'h04);
    acc(1, 1, OFS_HOST_IRQ_GATE, 32'h43);
    conv_val = 12'($urandom);
    acc(0, 1, OFS_SOFT_START, 0);
    acc(0, 0, OFS_CHAN_STATUS, 0);
    chk("busy", 32'h0, rv & 32'h1);
    for (int k = 0; k < 40 && host_irq_n_r !== 1'b0; k++) @(negedge clk_sys);
    chk("irq", 32'h0, 32'(host_irq_n_r));
    acc(0, 0, OFS_CHAN_STATUS, 0);
    chk("idle", 32'h1, rv & 32'h1);
    acc(0, 0, OFS_RESULT, 0);
    chk("result", {16'h0, r[3:0], conv_val}, rv);
    acc(1, 0, OFS_HOST_IRQ_GATE, 0);
    chk("flag set", 32'h47, rv);
    acc(0, 0, OFS_SOFT_START, 0);
    acc(1, 0, OFS_HOST_IRQ_GATE, 0);
    chk("flag clear", 32'h43, rv);
    chk("irq off", 32'h1, 32'(host_irq_n_r));
    $display("test conversion done");
    for (int s = 0; s < 8; s++) begin
      acc(0, 1, OFS_TRIG_IRQ_CTL, 32'(s * 4 + 1));
      starts = 0;
      ext_pulse();
      repeat (20) @(negedge clk_sys);
      chk("edge starts", 32'h1, 32'(starts));
      chk("src irq", 32'(!(s == 1 || s == 3)), 32'(host_irq_n_r));
      acc(0, 0, OFS_SOFT_START, 0);
    end
    $display("test sources done");
    acc(0, 1, OFS_TRIG_IRQ_CTL, 32'h00);
    starts = 0;
    @(negedge clk_sys) tmr_out.t0 = 1'b1;
    repeat (20) @(negedge clk_sys);
    tmr_out.t0 = 1'b0;
    chk("pacer", 32'h1, 32'(starts));
    acc(0, 1, OFS_TRIG_IRQ_CTL, 32'h02);
    chk("pre gate", 32'h1, 32'(tmr1_gate_r));
    starts = 0;
    tmr_out.t1 = 1'b1;
    repeat (20) @(negedge clk_sys);
    tmr_out.t1 = 1'b0;
    chk("pre starts", 32'h1, 32'(starts));
    ext_pulse();
    chk("pre stop", 32'h0, 32'(tmr1_gate_r));
    acc(0, 1, OFS_TRIG_IRQ_CTL, 32'h03);
    chk("post hold", 32'h0, 32'(tmr1_gate_r));
    ext_pulse();
    chk("post run", 32'h1, 32'(tmr1_gate_r));
    acc(0, 1, OFS_TRIG_IRQ_CTL, 32'h00);
    chk("mode end", 32'h0, 32'(tmr1_gate_r));
    acc(1, 1, OFS_HOST_IRQ_GATE, 32'h03);
    $display("test sequences done");
    for (int k = 0; k < 250; k++) begin
      tclk_p = tmr_clk_r;
      @(negedge clk_sys);
      if (!tclk_p && tmr_clk_r) tclk_n++;
    end
    chk("timer clock rises", 32'h0a, 32'(tclk_n));
    $display("test timer clock done");
    results();
  end
endmodule : daq_addon_control_logic_tb_top

// file: daq_addon_ctl.sv
/*
  Add-on control logic: register window, channel and gain select, status,
  digital ports, tagged result buffer, trigger source and interrupt source.
  Assumes the bridge delivers one-cycle rd/wr strobes synchronous to clk_sys,
  timers and converter sit outside, and all pin inputs are synchronous.
*/
// How it works
// - In general mode a write to 0x1C starts a conversion; a read of 0x1C clears the interrupt.
// - After reset the bridge interrupt gate is disabled, no host interrupt.
// - Gate bit 2 is read-only and shows the pending add-on interrupt.
// - Offset 0x20 writes the digital output latch, reads the digital input lines.
// - Result word: 12-bit value in bits 11-0, channel low bits in 15-12.
// - Status gives gain in 7-6, timers in 5,4,3, wiring type in bit 1.
// - Status bit 0 is zero while converting, one when idle.
// - Write to 0x10 selects channel: five bits single-ended, four bits differential.
// - Write to 0x14 keeps low two bits as gain code.
// - Channel and gain selections clear to zero on reset.
// - Control at 0x18: bits 4-2 interrupt source, bits 1-0 trigger method.
// - Sources: 1 done, 2 timer0 fall, 3 external fall, 4 timer1 fall; others off.
// - Methods: 0 general, 1 external edge, 2 pre-trigger, 3 post-trigger.
// - General mode triggers on timer 0 output and software writes.
// - External edge mode: one trigger per external falling edge.
// - Pre-trigger: timer 1 on and triggering until external falling edge, then stop.
// - Post-trigger: timer 1 held off until external falling edge, then triggers.
// - A write changing the trigger method ends any pre or post sequence.
// - Trigger method clears to general mode on reset.
// - Timer block clock is 4 MHz, one count per 0.25 us.
`timescale 1ns/1ps

module daq_addon_ctl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire daq_pkg::daq_io_req_s io_req,
  output logic [31:0] io_rdata_r,
  output logic io_rvalid_r,
  input wire logic [15:0] parallel_input_lines,
  output logic [15:0] dout_r,
  input wire logic single_ended,
  input wire logic ext_trig,
  input wire daq_pkg::daq_tmr_out_s tmr_out,
  output logic tmr_clk_r,
  output logic tmr1_gate_r,
  input wire daq_pkg::daq_adc_s adc_in,
  output logic adc_start_r,
  output logic [4:0] chan_sel_r,
  output logic [1:0] gain_r,
  output logic host_irq_n_r
);
  import daq_pkg::*;

  logic [6:0] gate_r;
  logic [2:0] src_r;
  daq_trig_e trig_r;
  daq_seq_e seq_r;
  daq_seq_e seq_nxt;
  logic [3:0] tag_r;
  logic [15:0] result_r;
  logic busy_r;
  logic irq_pend_r;
  logic ext_d_r;
  logic t0_d_r;
  logic t1_d_r;
  logic [4:0] div_r;

  logic add_wr;
  logic add_rd;
  logic br_wr;
  logic br_rd;
  logic ext_fall;
  logic t0_rise;
  logic t0_fall;
  logic t1_rise;
  logic t1_fall;
  logic soft_trig;
  logic ctl_wr;
  logic irq_evt;
  logic irq_clr;
  logic trig_now;
  logic [31:0] rdata_nxt;
  logic [7:0] status;

  assign add_wr = io_req.sel_addon & io_req.wr;
  assign add_rd = io_req.sel_addon & io_req.rd;
  assign br_wr = io_req.sel_bridge & io_req.wr;
  assign br_rd = io_req.sel_bridge & io_req.rd;

  assign ext_fall = ext_d_r & ~ext_trig;
  assign t0_rise = ~t0_d_r & tmr_out.t0;
  assign t0_fall = t0_d_r & ~tmr_out.t0;
  assign t1_rise = ~t1_d_r & tmr_out.t1;
  assign t1_fall = t1_d_r & ~tmr_out.t1;

  assign soft_trig = add_wr && io_req.addr == OFS_SOFT_START;
  assign irq_clr = add_rd && io_req.addr == OFS_SOFT_START;
  assign ctl_wr = add_wr && io_req.addr == OFS_TRIG_IRQ_CTL;

  // Edge history of the synchronous inputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_d_r <= 1'b1;
      t0_d_r <= 1'b0;
      t1_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_trig;
      t0_d_r <= tmr_out.t0;
      t1_d_r <= tmr_out.t1;
    end
  end

  // Timer block clock divider
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_r <= 5'h00;
      tmr_clk_r <= 1'b0;
    end else begin
      if (div_r == TMR_DIV_LAST) begin
        div_r <= 5'h00;
      end else begin
        div_r <= div_r + 5'h01;
      end
      tmr_clk_r <= (div_r < TMR_DIV_HALF);
    end
  end

  // Bridge interrupt gate register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gate_r <= GATE_RESET;
    end else if (br_wr && io_req.addr == OFS_HOST_IRQ_GATE) begin
      gate_r <= io_req.wdata[6:0];
    end
  end

  // Channel select, masked by the wiring strap at write time
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chan_sel_r <= CHAN_RESET;
    end else if (add_wr && io_req.addr == OFS_CHAN_STATUS) begin
      if (single_ended) begin
        chan_sel_r <= io_req.wdata[4:0];
      end else begin
        chan_sel_r <= {1'b0, io_req.wdata[3:0]};
      end
    end
  end

  // Gain code
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gain_r <= GAIN_RESET;
    end else if (add_wr && io_req.addr == OFS_GAIN) begin
      gain_r <= io_req.wdata[1:0];
    end
  end

  // Digital output latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dout_r <= 16'h0000;
    end else if (add_wr && io_req.addr == OFS_DIGITAL) begin
      dout_r <= io_req.wdata[15:0];
    end
  end

  // Trigger method
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trig_r <= TRIG_GENERAL;
    end else if (ctl_wr) begin
      trig_r <= daq_trig_e'(io_req.wdata[1:0]);
    end
  end

  // Interrupt source
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_r <= SRC_NONE;
    end else if (ctl_wr) begin
      src_r <= io_req.wdata[CTL_SRC_LSB +: 3];
    end
  end

  // Pre and post trigger sequence
  always_comb begin
    seq_nxt = seq_r;
    if (ctl_wr && io_req.wdata[1:0] != trig_r) begin
      unique case (daq_trig_e'(io_req.wdata[1:0]))
        TRIG_PRE: seq_nxt = SEQ_RUN;
        TRIG_POST: seq_nxt = SEQ_WAIT;
        TRIG_GENERAL,
        TRIG_EXT_EDGE: seq_nxt = SEQ_OFF;
      endcase
    end else begin
      unique case (seq_r)
        SEQ_OFF: seq_nxt = SEQ_OFF;
        SEQ_WAIT: begin
          if (ext_fall) begin
            seq_nxt = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (trig_r == TRIG_PRE && ext_fall) begin
            seq_nxt = SEQ_OFF;
          end
        end
        default: seq_nxt = SEQ_OFF;
      endcase
    end
  end

  // Timer 1 gate follows the next sequence state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seq_r <= SEQ_OFF;
      tmr1_gate_r <= 1'b0;
    end else begin
      seq_r <= seq_nxt;
      tmr1_gate_r <= (seq_nxt == SEQ_RUN);
    end
  end

  // Conversion trigger selection
  always_comb begin
    trig_now = 1'b0;
    unique case (trig_r)
      TRIG_GENERAL: trig_now = t0_rise | soft_trig;
      TRIG_EXT_EDGE: trig_now = ext_fall;
      TRIG_PRE,
      TRIG_POST: trig_now = (seq_r == SEQ_RUN) & t1_rise;
    endcase
  end

  // Converter start pulse, one cycle per trigger
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adc_start_r <= 1'b0;
    end else begin
      adc_start_r <= trig_now;
    end
  end

  // Busy flag; a new trigger wins over a finishing conversion
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else if (trig_now) begin
      busy_r <= 1'b1;
    end else if (adc_in.done) begin
      busy_r <= 1'b0;
    end
  end

  // Channel tag held from trigger to result
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tag_r <= 4'h0;
    end else if (trig_now) begin
      tag_r <= chan_sel_r[3:0];
    end
  end

  // Result word: channel tag over the converted value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result_r <= 16'h0000;
    end else if (adc_in.done) begin
      result_r <= {tag_r, adc_in.data};
    end
  end

  // Add-on interrupt source and pending flag
  always_comb begin
    irq_evt = 1'b0;
    unique case (src_r)
      SRC_CONV_DONE: irq_evt = adc_in.done;
      SRC_T0_FALL: irq_evt = t0_fall;
      SRC_EXT_FALL: irq_evt = ext_fall;
      SRC_T1_FALL: irq_evt = t1_fall;
      default: irq_evt = 1'b0;
    endcase
  end

  // Set wins over clear so an event in the clear cycle is kept
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_pend_r <= 1'b0;
    end else if (irq_evt) begin
      irq_pend_r <= 1'b1;
    end else if (irq_clr) begin
      irq_pend_r <= 1'b0;
    end
  end

  // Host request gated by the bridge enable bit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_irq_n_r <= 1'b1;
    end else begin
      host_irq_n_r <= ~(gate_r[GATE_EN_BIT] & irq_pend_r);
    end
  end

  // Status byte
  always_comb begin
    status = 8'h00;
    status[ST_GAIN_LSB +: 2] = gain_r;
    status[ST_T1_BIT] = tmr_out.t1;
    status[ST_T0_BIT] = tmr_out.t0;
    status[ST_T2_BIT] = tmr_out.t2;
    status[ST_SE_BIT] = single_ended;
    status[ST_IDLE_BIT] = ~busy_r;
  end

  // Read multiplexer
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (br_rd && io_req.addr == OFS_HOST_IRQ_GATE) begin
      rdata_nxt[6:0] = gate_r;
      rdata_nxt[GATE_FLAG_BIT] = irq_pend_r;
    end else if (add_rd) begin
      unique case (io_req.addr)
        OFS_CHAN_STATUS: rdata_nxt[7:0] = status;
        OFS_DIGITAL: rdata_nxt[15:0] = parallel_input_lines;
        OFS_RESULT: rdata_nxt[15:0] = result_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands one cycle, then returns to zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_rdata_r <= 32'h0000_0000;
      io_rvalid_r <= 1'b0;
    end else begin
      io_rdata_r <= rdata_nxt;
      io_rvalid_r <= br_rd | add_rd;
    end
  end

endmodule : daq_addon_ctl

// file: daq_addon_ctl_assertions.sv
/* Port checker for the add-on control logic.
   Assumes bind to daq_addon_ctl and one clock domain. */
`timescale 1ns/1ps
module daq_addon_ctl_chk
  import daq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire daq_pkg::daq_io_req_s io_req,
  input wire logic [31:0] io_rdata_r,
  input wire logic io_rvalid_r,
  input wire logic [15:0] parallel_input_lines,
  input wire logic [15:0] dout_r,
  input wire logic single_ended,
  input wire logic ext_trig,
  input wire daq_pkg::daq_tmr_out_s tmr_out,
  input wire logic tmr_clk_r,
  input wire logic tmr1_gate_r,
  input wire logic adc_start_r,
  input wire logic [4:0] chan_sel_r,
  input wire logic [1:0] gain_r,
  input wire logic host_irq_n_r
);
  logic [1:0] mode_r;
  logic wa, ra, w18, clr;
  assign wa = io_req.sel_addon && io_req.wr;
  assign ra = io_req.sel_addon && io_req.rd;
  assign w18 = wa && io_req.addr == OFS_TRIG_IRQ_CTL;
  assign clr = (ra && io_req.addr == OFS_SOFT_START) || (io_req.sel_bridge && io_req.wr);
  always_ff @(posedge clk_sys) begin
    if (srst) mode_r <= 2'h0;
    else if (w18) mode_r <= io_req.wdata[1:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_soft;
    wa && io_req.addr == OFS_SOFT_START && mode_r == 2'h0 |=> adc_start_r;
  endproperty
  a_soft: assert property (p_soft) else $error("soft start lost");
  property p_dout;
    wa && io_req.addr == OFS_DIGITAL |=> dout_r == $past(io_req.wdata[15:0]);
  endproperty
  a_dout: assert property (p_dout) else $error("output latch wrong");
  property p_chan;
    wa && io_req.addr == OFS_CHAN_STATUS |=> chan_sel_r == ($past(io_req.wdata[4:0]) & {$past(single_ended), 4'hf});
  endproperty
  a_chan: assert property (p_chan) else $error("channel wrong");
  property p_gain;
    wa && io_req.addr == OFS_GAIN |=> gain_r == $past(io_req.wdata[1:0]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_stat;
    ra && io_req.addr == OFS_CHAN_STATUS |=> io_rdata_r[7:1] == {$past(gain_r), $past(tmr_out.t1), $past(tmr_out.t0),
      $past(tmr_out.t2), 1'b0, $past(single_ended)};
  endproperty
  a_stat: assert property (p_stat) else $error("status wrong");
  property p_ext;
    mode_r == 2'h1 && $fell(ext_trig) |=> adc_start_r;
  endproperty
  a_ext: assert property (p_ext) else $error("edge start lost");
  property p_irq_hold;
    !host_irq_n_r && !clr && !$past(clr) |=> !host_irq_n_r;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
  property p_pre;
    w18 && io_req.wdata[1:0] == 2'h2 && mode_r != 2'h2 |=> tmr1_gate_r;
  endproperty
  a_pre: assert property (p_pre) else $error("gate not on");
  property p_post;
    w18 && io_req.wdata[1:0] == 2'h3 && mode_r != 2'h3 |=> !tmr1_gate_r;
  endproperty
  a_post: assert property (p_post) else $error("gate not off");
  property p_rst;
    disable iff (1'b0) srst |=> chan_sel_r == 5'h00 && gain_r == 2'h0 && host_irq_n_r;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_tmr_clk;
    $rose(tmr_clk_r) |-> ##12 $fell(tmr_clk_r) ##13 $rose(tmr_clk_r);
  endproperty
  a_tmr_clk: assert property (p_tmr_clk) else $error("timer clock period wrong");
  c_res: cover property (ra && io_req.addr == OFS_RESULT);
  c_pre: cover property (mode_r == 2'h2 && tmr1_gate_r ##1 !tmr1_gate_r);
  c_irq: cover property ($fell(host_irq_n_r));
endmodule : daq_addon_ctl_chk
bind daq_addon_ctl daq_addon_ctl_chk chk_u (.clk_sys(clk_sys), .srst(srst), .io_req(io_req), .io_rdata_r(io_rdata_r),
  .io_rvalid_r(io_rvalid_r), .parallel_input_lines(parallel_input_lines), .dout_r(dout_r), .single_ended(single_ended),
  .ext_trig(ext_trig), .tmr_out(tmr_out), .tmr_clk_r(tmr_clk_r), .tmr1_gate_r(tmr1_gate_r),
  .adc_start_r(adc_start_r),
  .chan_sel_r(chan_sel_r), .gain_r(gain_r), .host_irq_n_r(host_irq_n_r));

// file: daq_pkg.sv
/*
  Shared constants and carrier types for the add-on control logic of the
  acquisition card: register offsets, field positions, codes and timing.
  Assumes one 100 MHz system clock and a bridge that presents decoded I/O cycles.
*/
package daq_pkg;

  // Clocking
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned TMR_CLK_HZ = 4_000_000;
  localparam int unsigned TMR_DIV = SYS_CLK_HZ / TMR_CLK_HZ;
  localparam int unsigned TMR_HALF = TMR_DIV / 2;
  localparam logic [4:0] TMR_DIV_LAST = 5'(TMR_DIV - 1);
  localparam logic [4:0] TMR_DIV_HALF = 5'(TMR_HALF);

  // Add-on section offsets
  localparam logic [6:0] OFS_TIMER0 = 7'h00;
  localparam logic [6:0] OFS_TIMER1 = 7'h04;
  localparam logic [6:0] OFS_TIMER2 = 7'h08;
  localparam logic [6:0] OFS_TIMER_CTL = 7'h0c;
  localparam logic [6:0] OFS_CHAN_STATUS = 7'h10;
  localparam logic [6:0] OFS_GAIN = 7'h14;
  localparam logic [6:0] OFS_TRIG_IRQ_CTL = 7'h18;
  localparam logic [6:0] OFS_SOFT_START = 7'h1c;
  localparam logic [6:0] OFS_DIGITAL = 7'h20;
  localparam logic [6:0] OFS_RESULT = 7'h30;
  // Bridge section offset
  localparam logic [6:0] OFS_HOST_IRQ_GATE = 7'h4c;

  // Bridge interrupt gate fields
  localparam int unsigned GATE_EN_BIT = 6;
  localparam int unsigned GATE_FLAG_BIT = 2;
  localparam logic [6:0] GATE_RESET = 7'h00;

  // Status fields
  localparam int unsigned ST_GAIN_LSB = 6;
  localparam int unsigned ST_T1_BIT = 5;
  localparam int unsigned ST_T0_BIT = 4;
  localparam int unsigned ST_T2_BIT = 3;
  localparam int unsigned ST_SE_BIT = 1;
  localparam int unsigned ST_IDLE_BIT = 0;

  // Result word fields
  localparam int unsigned RES_TAG_LSB = 12;

  // Control register fields and reset values
  localparam int unsigned CTL_SRC_LSB = 2;
  localparam logic [4:0] CHAN_RESET = 5'h00;
  localparam logic [1:0] GAIN_RESET = 2'h0;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_CONV_DONE = 3'h1,
    SRC_T0_FALL = 3'h2,
    SRC_EXT_FALL = 3'h3,
    SRC_T1_FALL = 3'h4
  } daq_src_e;

  typedef enum logic [1:0] {
    TRIG_GENERAL = 2'h0,
    TRIG_EXT_EDGE = 2'h1,
    TRIG_PRE = 2'h2,
    TRIG_POST = 2'h3
  } daq_trig_e;

  typedef enum logic [2:0] {
    SEQ_OFF = 3'b001,
    SEQ_WAIT = 3'b010,
    SEQ_RUN = 3'b100
  } daq_seq_e;

  // One I/O cycle as decoded by the bridge
  typedef struct packed {
    logic sel_bridge;
    logic sel_addon;
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [31:0] wdata;
  } daq_io_req_s;

  // Converter side
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } daq_adc_s;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2;
  } daq_tmr_out_s;

endpackage : daq_pkg
